// ### src/rrd_pkg.sv
// Shared constants and types of the remote receive decoder
package rrd_pkg;
  // Clock and link timing
  localparam int unsigned CLK_HZ        = 20_000_000;
  localparam int unsigned ELEM_US       = 400;
  localparam int unsigned ELEM_CYC      = (CLK_HZ / 1_000_000) * ELEM_US;
  localparam int unsigned MS_CYC        = CLK_HZ / 1000;
  localparam int unsigned BAUD          = 9600;
  localparam int unsigned BAUD_CYC      = CLK_HZ / BAUD;
  localparam int unsigned FRAME_BITS    = 10;
  localparam int unsigned QUIET_ELEMS   = 6;

  // Human-scale timing, in millisecond ticks except ERASE_HOLD_S in seconds and BLINK_BIT, a bit of the millisecond count
  localparam int unsigned ERASE_HOLD_S  = 8;
  localparam int unsigned ERASE_HOLD_MS = ERASE_HOLD_S * 1000;
  localparam int unsigned FLASH_MS      = 3000;
  localparam int unsigned ERASE_STEP_MS = 20;
  localparam int unsigned PRESS_MAX_MS  = 100;
  localparam int unsigned RELEASE_MS    = 300;
  localparam int unsigned HOLD_MS       = 200;
  localparam int unsigned BLINK_BIT     = 8;

  // Sync: alternating run-in ending in one, then four zero elements
  localparam logic [7:0]  SYNC_PAT      = 8'h50;

  // Packet layout, least significant bit received first
  localparam int unsigned PKT_BITS      = 67;
  localparam int unsigned HOP_LSB       = 0;
  localparam int unsigned KEY_W         = 16;
  localparam int unsigned SER_LSB       = 32;
  localparam int unsigned SER_W         = 28;
  localparam int unsigned BTN_LSB       = 60;
  localparam int unsigned BTN_W         = 4;
  localparam int unsigned LOWBAT_BIT    = 64;
  localparam int unsigned ENTRIES       = 50;
  localparam int unsigned REPORT_BYTES  = 4;

  // Register map
  localparam int unsigned ADDR_W        = 12;
  localparam logic [11:0] CTRL_OFS      = 12'h000;
  localparam logic [11:0] STAT_OFS      = 12'h004;
  localparam logic [11:0] LAST_OFS      = 12'h008;
  localparam logic        CTRL_EN_RST   = 1'b1;
  localparam int unsigned STAT_MARK     = 3;
  localparam int unsigned STAT_MOM      = 4;
  localparam int unsigned STAT_IR       = 5;
  localparam int unsigned STAT_BUSY     = 6;
  localparam int unsigned STAT_CNT_LSB  = 8;

  typedef enum logic [2:0] {
    LS_IDLE, LS_HELD, LS_LRN1, LS_LRN2, LS_FLASH, LS_EHELD, LS_ERASE
  } rrd_learn_e;

  typedef enum logic {RX_HUNT, RX_DATA} rrd_rx_e;
endpackage

// ### src/rrd_tx_if.sv
// Byte handshake between the report sequencer and the serial transmitter
`timescale 1ns/1ps
interface rrd_tx_if;
  logic       valid;
  logic       ready;
  logic [7:0] data;
  modport src  (output valid, output data, input ready);
  modport sink (input valid, input data, output ready);
endinterface

// ### src/rrd_uart_tx.sv
// Serial report transmitter, 8 data bits, no parity, one stop bit
`timescale 1ns/1ps
module rrd_uart_tx
  import rrd_pkg::*;
(
  input  wire logic clk,
  input  wire logic reset,
  rrd_tx_if.sink    txIf,
  output logic      txd
);
  localparam int BW = $clog2(BAUD_CYC);

  logic [BW-1:0] baud_r;
  logic [3:0]    bitIdx_r;
  logic [9:0]    shift_r;
  logic          busy_r;

  // One byte in flight; the sequencer waits on ready meanwhile
  assign txIf.ready = !busy_r;

  // Frame shifter, start bit first, line idles high
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      baud_r   <= '0;
      bitIdx_r <= '0;
      shift_r  <= '1;
      busy_r   <= 1'b0;
      txd      <= 1'b1;
    end else if (!busy_r) begin
      if (txIf.valid) begin
        shift_r  <= {1'b1, txIf.data, 1'b0};
        busy_r   <= 1'b1;
        baud_r   <= '0;
        bitIdx_r <= '0;
        txd      <= 1'b0;
      end
    end else if (baud_r == BW'(BAUD_CYC - 1)) begin
      baud_r <= '0;
      if (bitIdx_r == 4'(FRAME_BITS - 1)) begin
        busy_r <= 1'b0;
      end else begin
        shift_r  <= shift_r >> 1;
        txd      <= shift_r[1];
        bitIdx_r <= bitIdx_r + 1'b1;
      end
    end else begin
      baud_r <= baud_r + 1'b1;
    end
  end

  a_stop_high: assert property (@(posedge clk) disable iff (reset)
    busy_r && bitIdx_r == 4'(FRAME_BITS - 1) |-> txd)
    else $error("stop bit not high");

  a_start_low: assert property (@(posedge clk) disable iff (reset)
    $rose(busy_r) |-> !txd ##1 !txd)
    else $error("start bit not low");
endmodule

// ### src/rrd_decoder.sv
// Remote receive decoder: Manchester receiver, learn store, outputs, APB
`timescale 1ns/1ps
// Functional notes
// - Four outputs, all latched or momentary
// - Sync zeros mean low mark, ones high
// - Read mark strap on clock pin, CS low
// - Brief learn press enters learn, indicator on
// - First valid transmission turns indicator off
// - Repeat from same button stores, then flashes
// - Fifty entries, full store overwrites oldest
// - Eight second hold selects full erase
// - Lit while held, flash erasing, dark done
// - Outputs mirror received encoder button states
// - Low battery shown only during flagged reception
// - Manchester, 400 us element, short timeout
// - No auto shut-off of held transmissions
// - Outputs driven only for learned encoders
// - Report any encoder with matching key
// - Report framing 9600, 8N1, no flow control
// - Output responds within 100 ms of press
// - Output responds within 300 ms of release
// - Strap selects radio or infrared input
module rrd_decoder
  import rrd_pkg::*;
#(
  parameter int unsigned ELEM_CYC_P = ELEM_CYC,
  parameter int unsigned MS_CYC_P   = MS_CYC,
  parameter logic [15:0] MFR_KEY    = 16'h5A3C // Arbitrary value
) (
  input  wire logic              clk,
  input  wire logic              reset,
  input  wire logic              rfData,
  input  wire logic              irData,
  input  wire logic              inputSourceStrap,
  input  wire logic              outputBehaviourStrap,
  input  wire logic              learnSw,
  input  wire logic              eeClkIn,
  output logic                   eeClkOut,
  output logic                   eeClkOe,
  output logic                   eeCs,
  output logic [BTN_W-1:0]       buttonOut,
  output logic                   lowBat,
  output logic                   learnLed,
  output logic                   txd,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr
);
  localparam int PW = $clog2(ELEM_CYC_P + 1);
  localparam int MW = $clog2(MS_CYC_P + 1);

  logic [5:0]          pinMeta_r, pinSync_r;
  logic                rfS, irS, inSrc, pulseOutputsSetting, learnS;
  logic                markHigh_r, ctrlEn_r;
  logic                rxPrev_r, rxIn, rxEdge, elemStb, elemVal;
  logic [PW-1:0]       phase_r;
  logic [2:0]          quiet_r;
  rrd_rx_e             rxState_r;
  logic [7:0]          hist_r, histNxt;
  logic                firstHalf_r, e1_r, pktDone_r, pktOk_r;
  logic [6:0]          bitCnt_r;
  logic [PKT_BITS-1:0] pkt_r;
  logic [SER_W-1:0]    rxSer, candSer_r;
  logic [BTN_W-1:0]    encoderButtonInputs, candBtn_r;
  logic                rxLow, keyOk, hit, learnMatch, storeEn, eraseStb;
  logic [SER_W-1:0]    ser_r [ENTRIES];
  logic [ENTRIES-1:0]  valid_r, hitVec;
  logic [5:0]          wrPtr_r, eraseIdx_r, count_r;
  logic [MW-1:0]       msCnt_r;
  logic                msTick_r;
  logic [BLINK_BIT:0]  msFree_r;
  rrd_learn_e          lState_r;
  logic [13:0]         tmr_r;
  logic [8:0]          holdTmr_r;
  logic [31:0]         rep_r, last_r, rdMux;
  logic [2:0]          repLeft_r;
  logic                apbAcc, mapped;

  rrd_tx_if txIf ();

  // Two-flop synchronisers for every pin from outside the clock domain
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pinMeta_r <= '0;
      pinSync_r <= '0;
    end else begin
      pinMeta_r <= {eeClkIn, learnSw, outputBehaviourStrap,
                    inputSourceStrap, irData, rfData};
      pinSync_r <= pinMeta_r;
    end
  end

  assign rfS                 = pinSync_r[0];
  assign irS                 = pinSync_r[1];
  assign inSrc               = pinSync_r[2];
  assign pulseOutputsSetting = pinSync_r[3]; // One strap sets all four
  assign learnS              = pinSync_r[4];

  // Memory is held in flops, so the clock pin is never driven and the
  // select stays low; the pin is then free to carry the mark strap
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      eeCs       <= 1'b0;
      eeClkOut   <= 1'b0;
      eeClkOe    <= 1'b0;
      markHigh_r <= 1'b0;
    end else begin
      eeCs     <= 1'b0;
      eeClkOut <= 1'b0;
      eeClkOe  <= 1'b0;
      if (!eeCs) begin
        markHigh_r <= pinSync_r[5];
      end
    end
  end

  // Element sampler: edges realign the phase, sampling mid-element
  assign rxIn    = inSrc ? irS : rfS;
  assign rxEdge  = rxIn ^ rxPrev_r;
  assign elemStb = !rxEdge && phase_r == PW'(ELEM_CYC_P / 2);
  assign elemVal = rxIn ^ markHigh_r; // Sync zeros read as zero at either mark level
  assign histNxt = {hist_r[6:0], elemVal};

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rxPrev_r <= 1'b0;
      phase_r  <= '0;
      quiet_r  <= '0;
    end else begin
      rxPrev_r <= rxIn;
      if (rxEdge || phase_r == PW'(ELEM_CYC_P - 1)) begin
        phase_r <= '0;
      end else begin
        phase_r <= phase_r + 1'b1;
      end
      // Short timeout: a few silent elements end any frame
      if (rxEdge) begin
        quiet_r <= '0;
      end else if (elemStb && quiet_r != 3'(QUIET_ELEMS)) begin
        quiet_r <= quiet_r + 1'b1;
      end
    end
  end

  // Frame receiver: hunt for sync, then decode element pairs
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rxState_r   <= RX_HUNT;
      hist_r      <= '0;
      firstHalf_r <= 1'b1;
      e1_r        <= 1'b0;
      bitCnt_r    <= '0;
      pkt_r       <= '0;
      pktDone_r   <= 1'b0;
    end else begin
      pktDone_r <= 1'b0;
      if (elemStb) begin
        hist_r <= (rxState_r == RX_DATA) ? 8'h00 : histNxt;
      end
      unique case (rxState_r)
        RX_HUNT: begin
          if (elemStb && ctrlEn_r && histNxt == SYNC_PAT) begin
            rxState_r   <= RX_DATA;
            firstHalf_r <= 1'b1;
            bitCnt_r    <= '0;
          end
        end
        RX_DATA: begin
          if (quiet_r == 3'(QUIET_ELEMS)) begin
            rxState_r <= RX_HUNT;
          end else if (elemStb) begin
            firstHalf_r <= !firstHalf_r;
            if (firstHalf_r) begin
              e1_r <= elemVal;
            end else if (e1_r == elemVal) begin
              rxState_r <= RX_HUNT; // No mid-bit transition
            end else begin
              pkt_r    <= {e1_r, pkt_r[PKT_BITS-1:1]};
              bitCnt_r <= bitCnt_r + 1'b1;
              if (bitCnt_r == 7'(PKT_BITS - 1)) begin
                pktDone_r <= 1'b1;
                rxState_r <= RX_HUNT;
              end
            end
          end
        end
      endcase
    end
  end

  // Payload fields; the key check stands in for full code validation
  assign rxSer = pkt_r[SER_LSB +: SER_W];
  assign encoderButtonInputs = pkt_r[BTN_LSB +: BTN_W];
  assign rxLow = pkt_r[LOWBAT_BIT];
  assign keyOk = (pkt_r[HOP_LSB +: KEY_W] ^ MFR_KEY)
                 == pkt_r[SER_LSB +: KEY_W];

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pktOk_r <= 1'b0;
    end else begin
      pktOk_r <= pktDone_r && keyOk;
    end
  end

  // Parallel match against every learned serial number
  genvar gi;
  generate
    for (gi = 0; gi < ENTRIES; gi++) begin : g_match
      assign hitVec[gi] = valid_r[gi] && ser_r[gi] == rxSer;
    end
  endgenerate
  assign hit        = |hitVec;
  assign learnMatch = lState_r == LS_LRN2 && pktOk_r
                      && rxSer == candSer_r
                      && encoderButtonInputs == candBtn_r;
  assign storeEn    = learnMatch && !hit; // Relearning adds no duplicate
  assign eraseStb   = lState_r == LS_ERASE && msTick_r
                      && tmr_r == 14'(ERASE_STEP_MS - 1);

  // Learned store, circular so the oldest entry is replaced first
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < ENTRIES; i++) begin
        ser_r[i] <= '0;
      end
      valid_r <= '0;
      wrPtr_r <= '0;
      count_r <= '0;
    end else if (storeEn) begin
      ser_r[wrPtr_r]   <= rxSer;
      valid_r[wrPtr_r] <= 1'b1;
      wrPtr_r <= (wrPtr_r == 6'(ENTRIES - 1)) ? 6'h00
                 : wrPtr_r + 1'b1;
      if (count_r != 6'(ENTRIES)) begin
        count_r <= count_r + 1'b1;
      end
    end else if (eraseStb) begin
      valid_r[eraseIdx_r] <= 1'b0;
      if (eraseIdx_r == 6'(ENTRIES - 1)) begin
        wrPtr_r <= '0;
        count_r <= '0;
      end
    end
  end

  // Millisecond tick and a free-running count for the flash rate
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      msCnt_r  <= '0;
      msTick_r <= 1'b0;
      msFree_r <= '0;
    end else if (msCnt_r == MW'(MS_CYC_P - 1)) begin
      msCnt_r  <= '0;
      msTick_r <= 1'b1;
      msFree_r <= msFree_r + 1'b1;
    end else begin
      msCnt_r  <= msCnt_r + 1'b1;
      msTick_r <= 1'b0;
    end
  end

  // Learn and erase sequencer driven by the learn switch
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      lState_r   <= LS_IDLE;
      tmr_r      <= '0;
      candSer_r  <= '0;
      candBtn_r  <= '0;
      eraseIdx_r <= '0;
    end else begin
      if (msTick_r) begin
        tmr_r <= tmr_r + 1'b1;
      end
      unique case (lState_r)
        LS_IDLE: begin
          if (learnS) begin
            lState_r <= LS_HELD;
            tmr_r    <= '0;
          end
        end
        LS_HELD: begin
          if (!learnS) begin
            lState_r <= LS_LRN1;
          end else if (msTick_r && tmr_r == 14'(ERASE_HOLD_MS - 1)) begin
            lState_r <= LS_EHELD;
          end
        end
        LS_LRN1: begin
          if (pktOk_r && !hit) begin
            lState_r  <= LS_LRN2;
            candSer_r <= rxSer;
            candBtn_r <= encoderButtonInputs;
          end
        end
        LS_LRN2: begin
          if (learnMatch) begin
            lState_r <= LS_FLASH;
            tmr_r    <= '0;
          end
        end
        LS_FLASH: begin
          if (msTick_r && tmr_r == 14'(FLASH_MS - 1)) begin
            lState_r <= LS_IDLE;
          end
        end
        LS_EHELD: begin
          if (!learnS) begin
            lState_r   <= LS_ERASE;
            tmr_r      <= '0;
            eraseIdx_r <= '0;
          end
        end
        LS_ERASE: begin
          if (eraseStb) begin
            tmr_r      <= '0;
            eraseIdx_r <= eraseIdx_r + 1'b1;
            if (eraseIdx_r == 6'(ENTRIES - 1)) begin
              lState_r <= LS_IDLE;
            end
          end
        end
        default: lState_r <= LS_IDLE;
      endcase
    end
  end

  // Indicator: steady while held or awaiting a first frame, blinking while busy
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      learnLed <= 1'b0;
    end else begin
      learnLed <= lState_r == LS_HELD || lState_r == LS_LRN1
                  || lState_r == LS_EHELD
                  || ((lState_r == LS_FLASH || lState_r == LS_ERASE)
                      && msFree_r[BLINK_BIT]);
    end
  end

  // Outputs follow each accepted frame; repeats keep them alive with
  // no cap, and the drop delay sits well inside the release bound
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      buttonOut <= '0;
      lowBat    <= 1'b0;
      holdTmr_r <= 9'(HOLD_MS);
    end else if (pktOk_r && hit) begin
      buttonOut <= encoderButtonInputs;
      lowBat    <= rxLow;
      holdTmr_r <= '0;
    end else begin
      if (msTick_r && holdTmr_r != 9'(HOLD_MS)) begin
        holdTmr_r <= holdTmr_r + 1'b1;
      end
      if (holdTmr_r == 9'(HOLD_MS)) begin
        lowBat <= 1'b0;
        if (pulseOutputsSetting) begin
          buttonOut <= '0;
        end
      end
    end
  end

  // Report sequencer; a frame arriving mid-report is not queued
  assign txIf.valid = repLeft_r != 3'h0;
  assign txIf.data  = rep_r[31:24];

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rep_r     <= '0;
      repLeft_r <= '0;
      last_r    <= '0;
    end else begin
      if (pktOk_r) begin
        last_r <= {encoderButtonInputs, rxSer};
      end
      if (repLeft_r == 3'h0) begin
        if (pktOk_r) begin
          rep_r     <= {encoderButtonInputs, rxSer};
          repLeft_r <= 3'(REPORT_BYTES);
        end
      end else if (txIf.ready) begin
        rep_r     <= rep_r << 8;
        repLeft_r <= repLeft_r - 1'b1;
      end
    end
  end

  rrd_uart_tx uTx (
    .clk   (clk),
    .reset (reset),
    .txIf  (txIf.sink),
    .txd   (txd)
  );

  // APB slave with one wait state so read data leaves a flop
  assign apbAcc = psel && penable && !pready;
  assign mapped = paddr == CTRL_OFS || paddr == STAT_OFS
                  || paddr == LAST_OFS;

  always_comb begin
    rdMux = '0;
    unique case (paddr)
      CTRL_OFS: rdMux[0] = ctrlEn_r;
      STAT_OFS: begin
        rdMux[2:0]       = lState_r;
        rdMux[STAT_MARK] = markHigh_r;
        rdMux[STAT_MOM]  = pulseOutputsSetting;
        rdMux[STAT_IR]   = inSrc;
        rdMux[STAT_BUSY] = rxState_r == RX_DATA;
        rdMux[STAT_CNT_LSB +: 6] = count_r;
      end
      LAST_OFS: rdMux = last_r;
      default:  rdMux = '0;
    endcase
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pready   <= 1'b0;
      prdata   <= '0;
      pslverr  <= 1'b0;
      ctrlEn_r <= CTRL_EN_RST;
    end else begin
      pready <= apbAcc;
      if (apbAcc) begin
        pslverr <= !mapped;
        prdata  <= pwrite ? 32'h0000_0000 : rdMux;
      end
      if (psel && penable && pready && pwrite && paddr == CTRL_OFS) begin
        ctrlEn_r <= pwdata[0];
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  sequence s_brief;
    lState_r == LS_HELD && !learnS;
  endsequence
  sequence s_first;
    lState_r == LS_LRN1 && pktOk_r && !hit;
  endsequence

  a_mark_sample: assert property (!eeCs ##1 !eeCs
    |-> markHigh_r == $past(pinSync_r[5]))
    else $error("mark strap not taken");
  a_sync_start: assert property ($rose(rxState_r == RX_DATA)
    |-> $past(elemStb) && $past(histNxt) == SYNC_PAT)
    else $error("frame began without sync");
  a_bad_code: assert property (rxState_r == RX_DATA && elemStb
    && !firstHalf_r && e1_r == elemVal && quiet_r != 3'(QUIET_ELEMS)
    |=> rxState_r == RX_HUNT && !pktDone_r)
    else $error("bad Manchester pair kept");
  a_out_learned: assert property ($changed(buttonOut)
    && buttonOut != '0 |-> $past(pktOk_r && hit))
    else $error("outputs set without learned frame");
  a_latch_hold: assert property (!pulseOutputsSetting
    && !(pktOk_r && hit) ##1 !pulseOutputsSetting
    |-> $stable(buttonOut))
    else $error("latched output changed");
  a_mom_drop: assert property (pulseOutputsSetting
    && holdTmr_r == 9'(HOLD_MS) && !(pktOk_r && hit)
    |=> buttonOut == '0 && !lowBat)
    else $error("momentary output did not drop");
  a_learn_enter: assert property (s_brief
    |=> lState_r == LS_LRN1 ##1 learnLed)
    else $error("brief press did not enter learn");
  a_learn_first: assert property (s_first
    |=> lState_r == LS_LRN2 ##1 !learnLed)
    else $error("first frame did not darken led");
  a_learn_store: assert property (storeEn
    |=> valid_r[$past(wrPtr_r)] && lState_r == LS_FLASH)
    else $error("learned entry not stored");
  a_store_wrap: assert property (storeEn && wrPtr_r == 6'(ENTRIES - 1)
    |=> wrPtr_r == 6'h00)
    else $error("store did not wrap to oldest");
  a_erase_hold: assert property ($rose(lState_r == LS_EHELD)
    |-> $past(tmr_r) == 14'(ERASE_HOLD_MS - 1) && $past(learnS))
    else $error("erase entered early");
  a_erase_dark: assert property (eraseStb && eraseIdx_r == 6'(ENTRIES - 1)
    |=> lState_r == LS_IDLE && valid_r == '0 ##1 !learnLed)
    else $error("erase end not dark or not empty");
endmodule

// ### tb/rrd_rx_model.sv
// Receiver module model that sends Manchester frames
`timescale 1ns/1ps
module rrd_rx_model #(
  parameter int EC = 40
) (
  input  wire logic clk,
  output logic      pin
);
  initial pin = 1'b0;
  // Edgeless gap, run-in, sync, then 67 bit pairs
  task automatic send(input logic [66:0] p, input logic mk,
                      input logic bad);
    logic [0:159] e;
    int           k;
    e = '0;
    for (k = 10; k < 18; k++) e[k] = k[0];
    e[19] = 1'b1;
    e[21] = 1'b1;
    for (k = 0; k < 67; k++) begin
      e[26+2*k] = p[k];
      e[27+2*k] = ~p[k] ^ (bad && k == 5);
    end
    for (k = 0; k < 160; k++) begin
      pin <= e[k] ^ mk;
      repeat (EC) @(posedge clk);
    end
    pin <= mk;
  endtask
endmodule

// ### tb/tb_rrd_decoder.sv
// Bench for the remote receive decoder
`timescale 1ns/1ps
module tb_rrd_decoder;
  import rrd_pkg::*;
  localparam logic [15:0] KEY = 16'h5A3C; // Arbitrary value
  localparam logic [27:0] SA  = 28'h9ABCDE1;
  localparam logic [27:0] SB  = 28'h1234567;
  logic        clk = 1'b0, reset = 1'b1, src = 1'b0, pulse_outputs_setting = 1'b1;
  logic        lsw = 1'b0, mark = 1'b1, rxPin, e;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic        pready, pslverr, txd, lowBat, learnLed;
  logic [3:0]  buttonOut;
  int          errors = 0, n_compared = 0, cyc = 0;
  // Clock cycles per millisecond tick, scaled down so erase fits the run
  localparam int MS = 2;
  always #25 clk = ~clk;
  rrd_rx_model #(.EC(40)) rx (.clk(clk), .pin(rxPin));
  rrd_decoder #(.ELEM_CYC_P(40), .MS_CYC_P(MS), .MFR_KEY(KEY)) DUT (
    .clk(clk), .reset(reset), .rfData(src ? 1'b0 : rxPin),
    .irData(src ? rxPin : 1'b0), .inputSourceStrap(src),
    .outputBehaviourStrap(pulse_outputs_setting), .learnSw(lsw), .eeClkIn(mark),
    .eeClkOut(), .eeClkOe(), .eeCs(), .buttonOut(buttonOut),
    .lowBat(lowBat), .learnLed(learnLed), .txd(txd), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));
  task automatic end_of_test();
    $display("errors %0d compared %0d", errors, n_compared);
    if (errors == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    n_compared++;
    if (g !== x) begin
      errors++;
      $display("mismatch at %0t: got %h want %h", $time, g, x);
    end
  endtask
  // One APB transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a);
    psel <= 1'b1; pwrite <= w; paddr <= a; penable <= 1'b0;
    @(posedge clk);
    penable <= 1'b1;
    // Only the bench timeout ends a wait that never sees pready
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic chkO(input logic [4:0] x);
    chk({27'h0, lowBat, buttonOut}, {27'h0, x});
  endtask
  task automatic fr(input logic [27:0] s, input logic [3:0] b,
                    input logic lb, input logic mk, input logic bad);
    rx.send({2'b00, lb, b, s, 16'h0000, s[15:0] ^ KEY}, mk, bad);
    repeat (4) @(posedge clk);
  endtask
  // Cut a hang short well above the expected run length
  always @(posedge clk) begin
    cyc++;
    if (cyc == 90000) begin
      errors++;
      end_of_test();
    end
  end
  // First report byte: start, 8 bits LSB first, stop
  initial begin : uart_mon
    logic [7:0] by;
    @(negedge reset);
    @(negedge txd);
    repeat (BAUD_CYC + BAUD_CYC / 2) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      by[i] = txd;
      repeat (BAUD_CYC) @(posedge clk);
    end
    chk({23'h0, txd, by}, 32'h119);
  end
  // Main sequence; outputs settle before each look
  initial begin
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    repeat (4) @(posedge clk);
    apb(1'b0, STAT_OFS);
    chk(q & 32'h38, 32'h18);
    apb(1'b0, 12'h00C);
    chk({q[31:1], e}, 32'h1);
    lsw <= 1'b1;
    repeat (5) @(posedge clk);
    chk({31'h0, learnLed}, 32'h1);
    lsw <= 1'b0;
    repeat (5) @(posedge clk);
    apb(1'b0, STAT_OFS);
    chk({29'h0, q[2:0]}, 32'h2);
    fr(SA, 4'h1, 1'b0, 1'b1, 1'b0);
    chk({31'h0, learnLed}, 32'h0);
    chkO(5'h00);
    apb(1'b0, LAST_OFS);
    chk(q, {4'h1, SA});
    fr(SA, 4'h1, 1'b0, 1'b1, 1'b0);
    apb(1'b0, STAT_OFS);
    chk(q & 32'h3F07, 32'h0104);
    fr(SA, 4'hA, 1'b1, 1'b1, 1'b0);
    chkO(5'h1A);
    repeat (RELEASE_MS * MS) @(posedge clk);
    chkO(5'h00);
    fr(SA, 4'h5, 1'b0, 1'b0, 1'b0);
    chkO(5'h00);
    fr(SA, 4'h6, 1'b0, 1'b1, 1'b1);
    chkO(5'h00);
    pulse_outputs_setting <= 1'b0;
    fr(SA, 4'h3, 1'b0, 1'b1, 1'b0);
    repeat (RELEASE_MS * MS) @(posedge clk);
    chkO(5'h03);
    src  <= 1'b1;
    mark <= 1'b0;
    fr(SA, 4'hC, 1'b0, 1'b0, 1'b0);
    chkO(5'h0C);
    fr(SB, 4'h7, 1'b0, 1'b0, 1'b0);
    chkO(5'h0C);
    apb(1'b0, LAST_OFS);
    chk(q, {4'h7, SB});
    // Long hold: still held just before the limit, erase selected just after
    lsw <= 1'b1;
    repeat (ERASE_HOLD_MS * MS - 100) @(posedge clk);
    apb(1'b0, STAT_OFS);
    chk({29'h0, q[2:0]}, 32'h1);
    repeat (200) @(posedge clk);
    apb(1'b0, STAT_OFS);
    chk({29'h0, q[2:0]}, 32'h5);
    chk({31'h0, learnLed}, 32'h1);
    lsw <= 1'b0;
    repeat (10) @(posedge clk);
    apb(1'b0, STAT_OFS);
    chk({29'h0, q[2:0]}, 32'h6);
    // The indicator must flip over one blink half period
    e = learnLed;
    repeat ((1 << BLINK_BIT) * MS) @(posedge clk);
    chk({31'h0, learnLed ^ e}, 32'h1);
    repeat (ENTRIES * ERASE_STEP_MS * MS) @(posedge clk);
    chk({31'h0, learnLed}, 32'h0);
    apb(1'b0, STAT_OFS);
    chk(q & 32'h3F07, 32'h0);
    end_of_test();
  end
endmodule
